//--- design/ptb_builder.sv
`timescale 1ns/1ps
module ptb_builder (
  input  wire logic         CLK_SYS,         // 20 MHz clock
  input  wire logic         SYS_RST,         // sync reset, high
  input  wire logic         BTN_EVENT,       // button event pulse
  input  wire logic         BTN_PRESS,       // 1 press, 0 release
  input  wire logic [3:0]   CONTACTS,        // contact inputs
  input  wire logic         COMM_REQ,        // commissioning pulse
  input  wire logic         RETX_REQ,        // repeat last telegram
  input  wire logic         ADDR_ROTATE_EN,  // rotating address mode
  input  wire logic [15:0]  MFR_ID,          // manufacturer id
  input  wire logic [1:0]   OPT_SIZE,        // optional data size
  input  wire logic [31:0]  OPT_DATA,        // optional user data
  input  wire logic [127:0] SEC_KEY,         // device security key
  input  wire logic [47:0]  SRC_ADDR,        // static source address
  output      logic         SIG_REQ,         // signature wanted
  output      logic [127:0] SIG_KEY,         // key for the cipher
  output      logic [103:0] SIG_NONCE,       // ccm nonce, byte 0 low
  output      logic [103:0] SIG_MSG,         // auth bytes, byte 0 low
  output      logic [3:0]   SIG_MSG_LEN,     // auth byte count
  input  wire logic         SIG_DONE,        // signature ready
  input  wire logic [31:0]  SIG_VALUE,       // signature, byte 0 low
  output      logic         OUT_VALID,       // payload byte valid
  input  wire logic         OUT_READY,       // radio takes byte
  output      logic [7:0]   OUT_DATA,        // payload byte
  output      logic         OUT_LAST,        // final payload byte
  output      logic         OUT_COMM,        // byte of commissioning
  output      logic         TX_STATIC_ADDR,  // frame uses static addr
  output      logic         BUSY,            // telegram in progress
  output      logic [31:0]  SEQ_VALUE        // next counter value
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_DIR,
    S_SAMPLE,
    S_BUILD,
    S_SIGN,
    S_EMIT
  } ptb_state_t;

  ptb_state_t         state_reg;
  ptb_state_t         state_next;
  logic               comm_reg;
  logic               have_reg;
  ptb_pkg::ptb_opt_t  opt_reg;
  logic [31:0]        seq_reg;
  logic [31:0]        tel_seq_reg;
  logic [47:0]        addr_reg;
  logic [127:0]       key_reg;
  logic [4:0]         idx_reg;
  logic [4:0]         last_reg;
  logic [7:0]         mem [ptb_pkg::PL_MAX];
  logic [7:0]         img [ptb_pkg::PL_MAX];
  logic [7:0]         status_byte;
  ptb_pkg::ptb_word_t fifo_in;
  ptb_pkg::ptb_word_t fifo_out;
  logic               fifo_in_ready;

  // derived selections
  wire ptb_pkg::ptb_opt_t opt_sel = ptb_pkg::ptb_opt_t'(OPT_SIZE);
  wire [2:0] nopt_cfg  = ptb_pkg::opt_bytes(opt_sel);
  wire [2:0] nopt      = ptb_pkg::opt_bytes(opt_reg);
  wire [7:0] len_cfg   = ptb_pkg::LEN_DATA0 + {5'h0, nopt_cfg};
  wire [4:0] last_data = ptb_pkg::LAST_DATA0 + {2'h0, nopt_cfg};
  wire [4:0] sig_pos   = 5'(ptb_pkg::OFS_OPT) + {2'h0, nopt};
  wire       start_tel = (BTN_EVENT || COMM_REQ) &&
                         state_reg == S_IDLE;
  wire       start_rtx = RETX_REQ && have_reg && !BTN_EVENT &&
                         !COMM_REQ && state_reg == S_IDLE;
  wire       push      = state_reg == S_EMIT;
  wire       push_ok   = push && fifo_in_ready;
  wire       push_last = idx_reg == last_reg;

  // one payload byte image; the tag slots are filled after signing
  function automatic logic [7:0] img_byte(input int i);
    logic [7:0] b;
    b = 8'h00;
    if (i == ptb_pkg::OFS_LEN) begin
      b = comm_reg ? ptb_pkg::LEN_COMM : len_cfg;
    end else if (i == ptb_pkg::OFS_TYPE) begin
      b = ptb_pkg::TYPE_MFR;
    end else if (i < ptb_pkg::OFS_SEQ) begin
      b = MFR_ID[8*(i-ptb_pkg::OFS_MFR) +: 8];
    end else if (i < ptb_pkg::OFS_STATUS) begin
      b = seq_reg[8*(i-ptb_pkg::OFS_SEQ) +: 8];
    end else if (comm_reg) begin
      if (i < ptb_pkg::OFS_ADDR) begin
        b = SEC_KEY[8*(i-ptb_pkg::OFS_KEY) +: 8];
      end else begin
        b = SRC_ADDR[8*(i-ptb_pkg::OFS_ADDR) +: 8];
      end
    end else if (i == ptb_pkg::OFS_STATUS) begin
      b = status_byte;
    end else if (i < ptb_pkg::OFS_OPT + 4 &&
                 i - ptb_pkg::OFS_OPT < int'(nopt_cfg)) begin
      b = OPT_DATA[8*(i-ptb_pkg::OFS_OPT) +: 8];
    end
    return b;
  endfunction : img_byte

  genvar gi;
  generate
    for (gi = 0; gi < ptb_pkg::PL_MAX; gi++) begin : g_img
      always_comb img[gi] = img_byte(gi); // wakes on the function's reads
    end
    for (gi = 0; gi < ptb_pkg::AUTH_MAX; gi++) begin : g_msg
      assign SIG_MSG[8*gi +: 8] = mem[gi];
    end
  endgenerate

  ptb_status_enc u_status (
    .clk        (CLK_SYS),
    .rst        (SYS_RST),
    .dir_stb    (state_reg == S_DIR),
    .press      (BTN_PRESS),
    .smp_stb    (state_reg == S_SAMPLE),
    .contacts   (CONTACTS),
    .status_reg (status_byte)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (COMM_REQ) state_next = S_BUILD;
        else if (BTN_EVENT) state_next = S_DIR;
        else if (start_rtx) state_next = S_EMIT;
      end
      S_DIR:    state_next = S_SAMPLE;
      S_SAMPLE: state_next = S_BUILD;
      S_BUILD:  state_next = comm_reg ? S_EMIT : S_SIGN;
      S_SIGN:   if (SIG_DONE) state_next = S_EMIT;
      S_EMIT:   if (push_ok && push_last) state_next = S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= S_IDLE;
      comm_reg  <= 1'b0;
      have_reg  <= 1'b0;
      opt_reg   <= ptb_pkg::OPT_NONE;
      seq_reg   <= ptb_pkg::SEQ_RST;
      last_reg  <= 5'h0;
      idx_reg   <= 5'h0;
    end else begin
      state_reg <= state_next;
      if (start_tel) comm_reg <= COMM_REQ;
      if (state_reg == S_BUILD) begin
        seq_reg  <= seq_reg + 32'h1;
        opt_reg  <= opt_sel;
        last_reg <= comm_reg ? ptb_pkg::LAST_COMM : last_data;
        have_reg <= 1'b1;
      end
      if (start_rtx || state_reg == S_BUILD) idx_reg <= 5'h0;
      else if (push_ok) idx_reg <= idx_reg + 5'h1;
    end
  end

  // payload store: kept whole so a repeat replays identical bytes
  always_ff @(posedge CLK_SYS) begin
    if (state_reg == S_BUILD) begin
      for (int i = 0; i < ptb_pkg::PL_MAX; i++) mem[i] <= img[i];
      tel_seq_reg <= seq_reg;
      addr_reg    <= SRC_ADDR;
      key_reg     <= SEC_KEY;
    end else if (state_reg == S_SIGN && SIG_DONE) begin
      for (int k = 0; k < 4; k++) begin
        mem[sig_pos + 5'(k)] <= SIG_VALUE[8*k +: 8];
      end
    end
  end

  assign SIG_REQ     = state_reg == S_SIGN;
  assign SIG_KEY     = key_reg;
  assign SIG_NONCE   = {ptb_pkg::NONCE_PAD, tel_seq_reg, addr_reg};
  assign SIG_MSG_LEN = 4'(ptb_pkg::OFS_OPT) + {1'b0, nopt};

  assign fifo_in.comm = comm_reg;
  assign fifo_in.last = push_last;
  assign fifo_in.data = mem[idx_reg];

  // the radio may stall; the builder then holds in S_EMIT
  ptb_fifo #(
    .W (10),
    .D (ptb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (fifo_out)
  );

  assign OUT_DATA       = fifo_out.data;
  assign OUT_LAST       = fifo_out.last;
  assign OUT_COMM       = fifo_out.comm;
  assign TX_STATIC_ADDR = fifo_out.comm || !ADDR_ROTATE_EN;
  assign BUSY           = state_reg != S_IDLE;
  assign SEQ_VALUE      = seq_reg;

  property p_data_len;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      state_reg == S_SIGN |-> mem[0] == 8'(last_reg);
  endproperty
  a_data_len: assert property (p_data_len)
    else $error("data length byte wrong");

  property p_type;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (state_reg == S_SIGN || state_reg == S_EMIT) |->
        mem[1] == 8'hFF;
  endproperty
  a_type: assert property (p_type)
    else $error("type byte is not 0xFF");

  property p_seq_step;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      state_reg == S_BUILD |=>
        seq_reg == $past(seq_reg) + 32'h1 && mem[4] == $past(seq_reg[7:0]);
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("counter did not advance by one");

  property p_retx_same;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      start_rtx |=> seq_reg == $past(seq_reg) && state_reg == S_EMIT;
  endproperty
  a_retx_same: assert property (p_retx_same)
    else $error("repeat changed the counter");

  property p_comm_size;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      push_ok && push_last && comm_reg |-> idx_reg == 5'h1D;
  endproperty
  a_comm_size: assert property (p_comm_size)
    else $error("commissioning payload not 30 bytes");

  property p_data_size;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      push_ok && push_last && !comm_reg |->
        idx_reg >= 5'h0C && idx_reg <= 5'h10 && idx_reg != 5'h0F;
  endproperty
  a_data_size: assert property (p_data_size)
    else $error("data payload size out of range");

  property p_order;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(SIG_REQ) |-> $past(state_reg) == S_BUILD &&
                         $past(state_reg, 2) == S_SAMPLE &&
                         $past(state_reg, 3) == S_DIR;
  endproperty
  a_order: assert property (p_order)
    else $error("event steps out of order");

  property p_static;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      OUT_VALID && OUT_COMM |-> TX_STATIC_ADDR;
  endproperty
  a_static: assert property (p_static)
    else $error("commissioning frame not on static address");
endmodule : ptb_builder

//--- common/ptb_pkg.sv
package ptb_pkg;

  // payload geometry
  localparam int          PL_MAX      = 30;
  localparam int          COMM_BYTES  = 30;
  localparam int          DATA_MIN    = 13;
  localparam int          DATA_MAX    = 17;
  localparam int          AUTH_MAX    = 13;
  localparam int          FIFO_DEPTH  = 16;

  // field offsets inside the payload
  localparam int          OFS_LEN     = 0;
  localparam int          OFS_TYPE    = 1;
  localparam int          OFS_MFR     = 2;
  localparam int          OFS_SEQ     = 4;
  localparam int          OFS_STATUS  = 8;
  localparam int          OFS_OPT     = 9;
  localparam int          OFS_KEY     = 8;
  localparam int          OFS_ADDR    = 24;

  // fixed field values
  localparam logic [7:0]  TYPE_MFR    = 8'hFF;
  localparam logic [7:0]  LEN_COMM    = 8'h1D;
  localparam logic [7:0]  LEN_DATA0   = 8'h0C;
  localparam logic [4:0]  LAST_COMM   = 5'h1D;
  localparam logic [4:0]  LAST_DATA0  = 5'h0C;
  localparam logic [31:0] SEQ_RST     = 32'h0000_0000;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [23:0] NONCE_PAD   = 24'h00_0000;

  // switch status layout
  localparam int          ST_ACTION   = 0;
  localparam int          ST_CONTACT  = 1;
  localparam int          ST_NCONT    = 4;

  typedef enum logic [1:0] {
    OPT_NONE,
    OPT_ONE,
    OPT_TWO,
    OPT_FOUR
  } ptb_opt_t;

  typedef struct packed {
    logic       comm;
    logic       last;
    logic [7:0] data;
  } ptb_word_t;

  function automatic logic [2:0] opt_bytes(input ptb_opt_t sz);
    case (sz)
      OPT_NONE: opt_bytes = 3'h0;
      OPT_ONE:  opt_bytes = 3'h1;
      OPT_TWO:  opt_bytes = 3'h2;
      default:  opt_bytes = 3'h4;
    endcase
  endfunction : opt_bytes

endpackage : ptb_pkg

//--- design/ptb_fifo.sv
`timescale 1ns/1ps
module ptb_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rst,       // sync reset, high
  input  wire logic         in_valid,  // write request
  output      logic         in_ready,  // room available
  input  wire logic [W-1:0] in_data,   // write word
  output      logic         out_valid, // word available
  input  wire logic         out_ready, // consumer takes word
  output      logic [W-1:0] out_data   // head word
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  wire          full  = (wr_reg[AW] != rd_reg[AW]) &&
                        (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire          empty = (wr_reg == rd_reg);
  wire          push  = in_valid && !full;
  wire          pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule : ptb_fifo

//--- design/ptb_status_enc.sv
`timescale 1ns/1ps
module ptb_status_enc (
  input  wire logic       clk,       // system clock
  input  wire logic       rst,       // sync reset, high
  input  wire logic       dir_stb,   // capture direction now
  input  wire logic       press,     // 1 press, 0 release
  input  wire logic       smp_stb,   // capture contacts now
  input  wire logic [3:0] contacts,  // first_low..second_high
  output      logic [7:0] status_reg // switch status byte
);
  logic       dir_reg;
  wire  [7:0] status_next = {3'h0, contacts, dir_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_reg    <= 1'b0;
      status_reg <= ptb_pkg::STATUS_RST;
    end else begin
      if (dir_stb) dir_reg <= press;
      if (smp_stb) status_reg <= status_next;
    end
  end

  property p_action_bit;
    @(posedge clk) disable iff (rst)
      dir_stb ##1 smp_stb |=> status_reg[0] == $past(press, 2);
  endproperty
  a_action_bit: assert property (p_action_bit)
    else $error("action bit does not follow direction");

  property p_contacts;
    @(posedge clk) disable iff (rst)
      smp_stb |=> status_reg[4:1] == $past(contacts) &&
                  status_reg[7:5] == 3'h0;
  endproperty
  a_contacts: assert property (p_contacts)
    else $error("contact bits or reserved bits wrong");
endmodule : ptb_status_enc

//--- tb/ptb_radio_model.sv
`timescale 1ns/1ps
module ptb_radio_model (
  input  wire logic       clk,   // system clock
  input  wire logic       rst,   // sync reset, high
  input  wire logic       slow,  // stall most cycles
  input  wire logic       valid, // byte offered
  input  wire logic [7:0] data,  // payload byte
  input  wire logic       last,  // final byte
  input  wire logic       comm,  // commissioning byte
  output      logic       ready  // byte taken
);
  ptb_pkg::ptb_word_t got_q[$];
  ptb_pkg::ptb_word_t fr_q[$];
  logic [31:0]        seq_ok;
  logic               seen;
  int                 rejects;
  logic [4:0]         cnt;

  // slow mode takes one byte in 32 so the fifo runs full
  always_ff @(posedge clk) begin
    cnt   <= rst ? 5'h00 : cnt + 5'h01;
    ready <= slow ? (cnt == 5'h00) : ($urandom_range(3) != 0);
  end

  always @(posedge clk) begin : rx
    logic [31:0] s;
    if (rst) begin
      seen = 1'b0;
      rejects = 0;
      fr_q.delete();
    end else if (valid === 1'b1 && ready === 1'b1) begin
      got_q.push_back('{comm, last, data});
      fr_q.push_back('{comm, last, data});
      if (last) begin
        s = {fr_q[7].data, fr_q[6].data, fr_q[5].data, fr_q[4].data};
        // a replayed counter is not news to a receiver
        if (seen && s <= seq_ok) rejects++;
        else begin
          seq_ok = s;
          seen = 1'b1;
        end
        fr_q.delete();
      end
    end
  end
endmodule : ptb_radio_model

//--- tb/ptb_builder_tb.sv
`timescale 1ns/1ps
module ptb_builder_tb;
  logic CLK_SYS = 0, SYS_RST = 1, BTN_EVENT = 0, BTN_PRESS = 0;
  logic COMM_REQ = 0, RETX_REQ = 0, ADDR_ROTATE_EN = 0, SIG_DONE = 0;
  logic slow = 0;
  logic [3:0]   CONTACTS = 4'h0;
  logic [15:0]  MFR_ID = 16'h0000;
  logic [1:0]   OPT_SIZE = 2'h0;
  logic [31:0]  OPT_DATA = 32'h0, SIG_VALUE = 32'h0;
  logic [127:0] SEC_KEY = 128'h0;
  logic [47:0]  SRC_ADDR = 48'h0;
  logic SIG_REQ, OUT_VALID, OUT_READY, OUT_LAST, OUT_COMM, BUSY;
  logic TX_STATIC_ADDR;
  logic [127:0] SIG_KEY;
  logic [103:0] SIG_NONCE, SIG_MSG;
  logic [3:0]   SIG_MSG_LEN;
  logic [7:0]   OUT_DATA;
  logic [31:0]  SEQ_VALUE, seq;
  int miscompares, tests_run, cycles, retx_n;
  ptb_pkg::ptb_word_t exp_q[$];

  ptb_builder dut_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .BTN_EVENT(BTN_EVENT), .BTN_PRESS(BTN_PRESS), .CONTACTS(CONTACTS),
    .COMM_REQ(COMM_REQ), .RETX_REQ(RETX_REQ),
    .ADDR_ROTATE_EN(ADDR_ROTATE_EN), .MFR_ID(MFR_ID),
    .OPT_SIZE(OPT_SIZE), .OPT_DATA(OPT_DATA), .SEC_KEY(SEC_KEY),
    .SRC_ADDR(SRC_ADDR), .SIG_REQ(SIG_REQ), .SIG_KEY(SIG_KEY),
    .SIG_NONCE(SIG_NONCE), .SIG_MSG(SIG_MSG), .SIG_MSG_LEN(SIG_MSG_LEN),
    .SIG_DONE(SIG_DONE), .SIG_VALUE(SIG_VALUE), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
    .OUT_COMM(OUT_COMM), .TX_STATIC_ADDR(TX_STATIC_ADDR), .BUSY(BUSY),
    .SEQ_VALUE(SEQ_VALUE));
  ptb_radio_model rx_u (.clk(CLK_SYS), .rst(SYS_RST), .slow(slow),
    .valid(OUT_VALID), .data(OUT_DATA), .last(OUT_LAST),
    .comm(OUT_COMM), .ready(OUT_READY));

  initial forever #25 CLK_SYS = ~CLK_SYS;

  task automatic check(input string name, input logic [127:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task conclude;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  function automatic int nopt(input logic [1:0] s);
    return (s == 2'h3) ? 4 : int'(s);
  endfunction : nopt

  function void push(input logic c, input logic [7:0] d);
    exp_q.push_back('{c, 1'b0, d});
  endfunction : push

  function void exp_build(input logic c, input logic [7:0] st,
                          input logic [31:0] sg);
    int n;
    n = nopt(OPT_SIZE);
    exp_q.delete();
    push(c, c ? 8'h1D : 8'(12 + n));
    push(c, 8'hFF);
    for (int j = 0; j < 2; j++) push(c, MFR_ID[8*j+:8]);
    for (int j = 0; j < 4; j++) push(c, seq[8*j+:8]);
    if (c) begin
      for (int j = 0; j < 16; j++) push(c, SEC_KEY[8*j+:8]);
      for (int j = 0; j < 6; j++) push(c, SRC_ADDR[8*j+:8]);
    end else begin
      push(c, st);
      for (int j = 0; j < n; j++) push(c, OPT_DATA[8*j+:8]);
      for (int j = 0; j < 4; j++) push(c, sg[8*j+:8]);
    end
    exp_q[$].last = 1'b1;
  endfunction : exp_build

  task telegram(input int kind, input logic sl, input logic [1:0] os);
    logic p;
    logic [3:0] ct;
    logic [31:0] sg;
    int w;
    int n;
    p = $urandom;
    ct = $urandom;
    sg = $urandom;
    @(posedge CLK_SYS);
    slow <= sl;
    MFR_ID <= $urandom;
    OPT_SIZE <= os;
    OPT_DATA <= $urandom;
    SEC_KEY <= {$urandom, $urandom, $urandom, $urandom};
    SRC_ADDR <= 48'({$urandom, $urandom});
    ADDR_ROTATE_EN <= $urandom;
    BTN_PRESS <= p;
    CONTACTS <= ct;
    @(posedge CLK_SYS);
    BTN_EVENT <= (kind == 0);
    COMM_REQ <= (kind == 1);
    RETX_REQ <= (kind == 2);
    @(posedge CLK_SYS);
    BTN_EVENT <= 1'b0;
    COMM_REQ <= 1'b0;
    RETX_REQ <= 1'b0;
    n = nopt(OPT_SIZE);
    // a replay keeps the old image even though the inputs moved on
    if (kind != 2) exp_build(kind == 1, {3'b000, ct, p}, sg);
    if (kind == 0) begin
      w = 0;
      while (SIG_REQ !== 1'b1 && w < 20) begin
        @(negedge CLK_SYS);
        w++;
      end
      check("sig_len", SIG_MSG_LEN, 9 + n);
      check("sig_key", SIG_KEY, SEC_KEY);
      check("sig_nonce", SIG_NONCE, {24'h0, seq, SRC_ADDR});
      for (int j = 0; j < 9 + n; j++)
        check("sig_msg", SIG_MSG[8*j+:8], exp_q[j].data);
      @(posedge CLK_SYS);
      BTN_PRESS <= !p;
      CONTACTS <= ~ct;
      BTN_EVENT <= 1'b1;
      COMM_REQ <= 1'b1;
      repeat ($urandom_range(4)) @(posedge CLK_SYS);
      @(posedge CLK_SYS);
      BTN_EVENT <= 1'b0;
      COMM_REQ <= 1'b0;
      SIG_DONE <= 1'b1;
      SIG_VALUE <= sg;
      @(posedge CLK_SYS);
      SIG_DONE <= 1'b0;
      SIG_VALUE <= ~sg;
    end
    w = 0;
    while ((rx_u.got_q.size() < exp_q.size() || BUSY !== 1'b0)
           && w < 3000) begin
      @(negedge CLK_SYS);
      w++;
    end
    check("bytes", rx_u.got_q.size(), exp_q.size());
    for (int j = 0; j < exp_q.size(); j++)
      check("byte", rx_u.got_q[j], exp_q[j]);
    rx_u.got_q.delete();
    if (kind != 2) seq++;
    else retx_n++;
    check("seq", SEQ_VALUE, seq);
  endtask : telegram

  always @(negedge CLK_SYS)
    if (OUT_VALID === 1'b1)
      check("static", TX_STATIC_ADDR, OUT_COMM | !ADDR_ROTATE_EN);

  // covers the slowest mix of telegrams with ample margin
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    int k;
    void'($urandom(32'hDC9BBD9E));
    seq = 32'h0;
    repeat (3) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    @(negedge CLK_SYS);
    check("seq_rst", SEQ_VALUE, 32'h0);
    check("busy_rst", {BUSY, OUT_VALID, SIG_REQ}, 3'h0);
    for (int i = 0; i < 24; i++) begin
      k = (i < 4) ? 0 : (i == 4 || i == 7) ? 1 : (i == 5) ? 2
          : $urandom_range(2);
      telegram(k, i == 6 || i == 7 || i % 9 == 8, 2'(i));
    end
    check("rejects", rx_u.rejects, retx_n);
    conclude();
  end
endmodule : ptb_builder_tb
